// ---- hdl/pwm_phase_deadtime_trigger.sv ----
module pwm_phase_deadtime_trigger (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic high_output_out,
  output logic low_output_out,
  output logic trigger_primary_out,
  output logic trigger_secondary_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] secondary_duty;
    logic [15:0] primary_phase_shift;
    logic [15:0] secondary_phase_shift;
    logic [15:0] dead_time_primary;
    logic [15:0] dead_time_alternate;
    logic [15:0] trigger_control;
    logic [15:0] generator_control;
    logic [15:0] primary_duty;
    logic [15:0] master_period;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [15:0] count_high;
    logic [15:0] count_low;
    logic [5:0] start_count;
    logic started;
    logic [3:0] div_primary;
    logic [3:0] div_secondary;
    logic [31:0] rdata;
    logic ack;
    logic high_out;
    logic low_out;
    logic trg_primary;
    logic trg_secondary;
    logic irq;
  } pwm_state_s;

  pwm_state_s state_reg;
  pwm_state_s state_next;

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  logic enable;
  logic indep_period;
  pwm_gen_pkg::pin_pair_mode_e mode;
  logic is_indep;
  logic [15:0] period_high;
  logic [15:0] period_low;
  logic [15:0] phase_high;
  logic [15:0] phase_low;
  logic [15:0] duty_high;
  logic [15:0] duty_low;
  logic [15:0] adj_high;
  logic [15:0] adj_low;
  logic wrap_high;
  logic wrap_low;
  logic sec_event;
  logic pri_event;
  logic [3:0] div_n;
  logic dual;
  logic pass_primary;
  logic pass_secondary;
  logic bus_req;
  logic bus_wr;
  logic [15:0] wdata;
  logic [2:0] irq_events;

  function automatic logic [15:0] clamp_duty(input logic [15:0] d, input logic [15:0] hi);
    logic [15:0] r;
    r = d;
    if (d < pwm_gen_pkg::DUTY_MIN) begin
      r = 16'h0000;
    end else if (d > hi) begin
      r = hi;
    end
    return r;
  endfunction

  always_comb begin
    enable = state_reg.generator_control[pwm_gen_pkg::CTRL_ENABLE_BIT];
    indep_period = state_reg.generator_control[pwm_gen_pkg::CTRL_INDEP_BIT];
    mode = pwm_gen_pkg::pin_pair_mode_e'(
      state_reg.generator_control[pwm_gen_pkg::CTRL_MODE_LSB +: 2]);
    is_indep = (mode == pwm_gen_pkg::MODE_INDEPENDENT);
    // Period source selection
    period_high = state_reg.master_period;
    period_low = state_reg.master_period;
    phase_high = 16'h0000;
    phase_low = 16'h0000;
    if (indep_period) begin
      if (is_indep) begin
        period_low = state_reg.primary_phase_shift;
        phase_low = state_reg.secondary_phase_shift;
      end else begin
        period_high = state_reg.primary_phase_shift;
        period_low = state_reg.primary_phase_shift;
      end
    end else begin
      if (is_indep) begin
        phase_low = state_reg.primary_phase_shift + state_reg.secondary_phase_shift;
      end else begin
        phase_high = state_reg.primary_phase_shift;
        phase_low = state_reg.primary_phase_shift;
      end
    end
    // Duty selection and limits
    duty_high = clamp_duty(state_reg.primary_duty, pwm_gen_pkg::DUTY_MAX);
    duty_low = duty_high;
    if (is_indep) begin
      duty_low = clamp_duty(state_reg.secondary_duty, pwm_gen_pkg::DUTY_MAX);
    end
    if (indep_period) begin
      duty_high = clamp_duty(duty_high, period_high - pwm_gen_pkg::DUTY_MIN);
      duty_low = clamp_duty(duty_low, period_low - pwm_gen_pkg::DUTY_MIN);
    end
    // Resolution coarsens to 8 LSB inside the near-edge zone
    if (duty_high < 16'(pwm_gen_pkg::EDGE_ZONE_CYCLES)) begin
      duty_high = {duty_high[15:3], 3'b000};
    end
    if (duty_low < 16'(pwm_gen_pkg::EDGE_ZONE_CYCLES)) begin
      duty_low = {duty_low[15:3], 3'b000};
    end
    adj_high = state_reg.count_high + phase_high;
    adj_low = state_reg.count_low + phase_low;
    wrap_high = enable && (state_reg.count_high >= period_high);
    wrap_low = enable && (state_reg.count_low >= period_low);
    // Trigger events
    pri_event = wrap_high;
    sec_event = wrap_low && is_indep;
    div_n = state_reg.trigger_control[pwm_gen_pkg::TRG_DIV_LSB +: 4];
    dual = state_reg.trigger_control[pwm_gen_pkg::TRG_DUAL_BIT];
    pass_primary = state_reg.started && (pri_event || (dual && sec_event)) &&
                   (state_reg.div_primary == div_n);
    pass_secondary = state_reg.started && !dual && sec_event &&
                     (state_reg.div_secondary == div_n);
    bus_req = wb_cyc_in && wb_stb_in && !state_reg.ack;
    bus_wr = bus_req && wb_we_in;
    wdata = wb_dat_in[15:0];
    irq_events = {pri_event, 1'b0, pass_primary};

    state_next = state_reg;
    state_next.ack = bus_req;
    state_next.trg_primary = pass_primary;
    state_next.trg_secondary = pass_secondary;

    // ----------------------------------------------------------------
    // Time bases
    // ----------------------------------------------------------------
    if (!enable) begin
      state_next.count_high = 16'h0000;
      state_next.count_low = 16'h0000;
      state_next.started = 1'b0;
      state_next.start_count = 6'h00;
      state_next.div_primary = 4'h0;
      state_next.div_secondary = 4'h0;
    end else begin
      state_next.count_high = wrap_high ? 16'h0000 : state_reg.count_high + 16'h0001;
      state_next.count_low = wrap_low ? 16'h0000 : state_reg.count_low + 16'h0001;
      // Start delay in whole PWM cycles
      if (!state_reg.started) begin
        if (state_reg.start_count ==
            state_reg.trigger_control[pwm_gen_pkg::TRG_START_LSB +: 6]) begin
          state_next.started = 1'b1;
        end else if (wrap_high) begin
          state_next.start_count = state_reg.start_count + 6'h01;
        end
      end
      if (state_reg.started && (pri_event || (dual && sec_event))) begin
        state_next.div_primary = (state_reg.div_primary == div_n) ? 4'h0 :
                                 state_reg.div_primary + 4'h1;
      end
      if (state_reg.started && !dual && sec_event) begin
        state_next.div_secondary = (state_reg.div_secondary == div_n) ? 4'h0 :
                                   state_reg.div_secondary + 4'h1;
      end
    end
    state_next.high_out = enable && (adj_high < duty_high);
    if (is_indep) begin
      state_next.low_out = enable && (adj_low < duty_low);
    end else if (mode == pwm_gen_pkg::MODE_COMPLEMENTARY) begin
      state_next.low_out = enable && !(adj_high < duty_high);
    end else begin
      state_next.low_out = enable && (adj_high < duty_high);
    end

    // ----------------------------------------------------------------
    // Interrupt status, set wins over clear
    // ----------------------------------------------------------------
    if (bus_wr && wb_adr_in == pwm_gen_pkg::ADDR_IRQ_STATUS && wb_sel_in[0]) begin
      state_next.irq_status = state_reg.irq_status & ~wb_dat_in[2:0];
    end
    state_next.irq_status = state_next.irq_status | irq_events;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (bus_wr && (&wb_sel_in[1:0])) begin
      if (wb_adr_in == pwm_gen_pkg::ADDR_SECONDARY_DUTY) begin
        state_next.secondary_duty = wdata;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_PRIMARY_PHASE) begin
        state_next.primary_phase_shift = wdata;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_SECONDARY_PHASE) begin
        state_next.secondary_phase_shift = wdata;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_DEAD_PRIMARY) begin
        state_next.dead_time_primary = wdata & pwm_gen_pkg::DEAD_TIME_MASK;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_DEAD_ALTERNATE) begin
        state_next.dead_time_alternate = wdata & pwm_gen_pkg::DEAD_TIME_MASK;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_TRIGGER_CONTROL) begin
        state_next.trigger_control = wdata & pwm_gen_pkg::TRIGGER_CONTROL_MASK;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_GENERATOR_CONTROL) begin
        state_next.generator_control = wdata & pwm_gen_pkg::GENERATOR_CONTROL_MASK;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_PRIMARY_DUTY) begin
        state_next.primary_duty = wdata;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_MASTER_PERIOD) begin
        state_next.master_period = wdata;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_IRQ_MASK) begin
        state_next.irq_mask = wdata[2:0];
      end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    state_next.rdata = 32'h0000_0000;
    if (bus_req && !wb_we_in) begin
      if (wb_adr_in == pwm_gen_pkg::ADDR_SECONDARY_DUTY) begin
        state_next.rdata[15:0] = state_reg.secondary_duty;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_PRIMARY_PHASE) begin
        state_next.rdata[15:0] = state_reg.primary_phase_shift;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_SECONDARY_PHASE) begin
        state_next.rdata[15:0] = state_reg.secondary_phase_shift;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_DEAD_PRIMARY) begin
        state_next.rdata[15:0] = state_reg.dead_time_primary;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_DEAD_ALTERNATE) begin
        state_next.rdata[15:0] = state_reg.dead_time_alternate;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_TRIGGER_CONTROL) begin
        state_next.rdata[15:0] = state_reg.trigger_control;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_GENERATOR_CONTROL) begin
        state_next.rdata[15:0] = state_reg.generator_control;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_PRIMARY_DUTY) begin
        state_next.rdata[15:0] = state_reg.primary_duty;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_MASTER_PERIOD) begin
        state_next.rdata[15:0] = state_reg.master_period;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_IRQ_STATUS) begin
        state_next.rdata[2:0] = state_reg.irq_status;
      end else if (wb_adr_in == pwm_gen_pkg::ADDR_IRQ_MASK) begin
        state_next.rdata[2:0] = state_reg.irq_mask;
      end
    end
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg <= '0;
      state_reg.master_period <= pwm_gen_pkg::RESET_PERIOD;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_out = state_reg.rdata;
  assign wb_ack_out = state_reg.ack;
  assign high_output_out = state_reg.high_out;
  assign low_output_out = state_reg.low_out;
  assign trigger_primary_out = state_reg.trg_primary;
  assign trigger_secondary_out = state_reg.trg_secondary;
  assign irq_out = state_reg.irq;

endmodule // pwm_phase_deadtime_trigger

// ---- hdl/pwm_gen_pkg.sv ----
package pwm_gen_pkg;

  // ----------------------------------------------------------------
  // Register word addresses (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SECONDARY_DUTY = 8'h00;
  localparam logic [7:0] ADDR_PRIMARY_PHASE = 8'h04;
  localparam logic [7:0] ADDR_SECONDARY_PHASE = 8'h08;
  localparam logic [7:0] ADDR_DEAD_PRIMARY = 8'h0C;
  localparam logic [7:0] ADDR_DEAD_ALTERNATE = 8'h10;
  localparam logic [7:0] ADDR_TRIGGER_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_GENERATOR_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_PRIMARY_DUTY = 8'h1C;
  localparam logic [7:0] ADDR_MASTER_PERIOD = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] RESET_PERIOD = 16'hFFFF;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] DEAD_TIME_MASK = 16'h3FFF;
  localparam logic [15:0] TRIGGER_CONTROL_MASK = 16'hF0BF;
  localparam int TRG_DIV_LSB = 12;
  localparam int TRG_DUAL_BIT = 7;
  localparam int TRG_START_LSB = 0;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_INDEP_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam logic [15:0] GENERATOR_CONTROL_MASK = 16'h000F;

  // Interrupt status bits
  localparam int IRQ_PRIMARY_TRIGGER_BIT = 0;
  localparam int IRQ_SECONDARY_TRIGGER_BIT = 1;
  localparam int IRQ_PERIOD_BIT = 2;
  localparam int IRQ_WIDTH = 3;

  // ----------------------------------------------------------------
  // Pulse limits
  // ----------------------------------------------------------------
  localparam logic [15:0] DUTY_MIN = 16'h0008;
  localparam logic [15:0] DUTY_MAX = 16'hFFEF;

  // Near-edge zone, 40 ns at 4 ns per count
  localparam int EDGE_ZONE_NS = 40;
  localparam int CLK_PERIOD_NS = 4;
  localparam int EDGE_ZONE_CYCLES = EDGE_ZONE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Pin pair modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_COMPLEMENTARY = 2'b00,
    MODE_REDUNDANT = 2'b01,
    MODE_PUSH_PULL = 2'b10,
    MODE_INDEPENDENT = 2'b11
  } pin_pair_mode_e;

endpackage

// ---- testbench/pwm_power_stage_model.sv ----
// ----------------------------------------------------------------
// Power stage model: measures pulse widths on the output pair
// ----------------------------------------------------------------
module pwm_power_stage_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic high_output_in,
  input wire logic low_output_in,
  output logic [15:0] high_width_out,
  output logic [15:0] low_width_out,
  output logic [15:0] low_rises_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] high_run_reg;
  logic [15:0] low_run_reg;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      high_run_reg <= 16'h0000;
      low_run_reg <= 16'h0000;
      high_width_out <= 16'h0000;
      low_width_out <= 16'h0000;
      low_rises_out <= 16'h0000;
    end else begin
      high_run_reg <= high_output_in ? high_run_reg + 16'h0001 : 16'h0000;
      low_run_reg <= low_output_in ? low_run_reg + 16'h0001 : 16'h0000;
      if (!high_output_in && high_run_reg != 16'h0000) high_width_out <= high_run_reg;
      if (!low_output_in && low_run_reg != 16'h0000) low_width_out <= low_run_reg;
      if (low_output_in && low_run_reg == 16'h0000) low_rises_out <= low_rises_out + 16'h0001;
    end
  end
endmodule // pwm_power_stage_model

// ---- testbench/pwm_phase_deadtime_trigger_checker.sv ----
module pwm_phase_deadtime_trigger_checker (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic high_output_out,
  input wire logic low_output_out,
  input wire logic trigger_primary_out,
  input wire logic trigger_secondary_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // Shadow of written control fields
  // ----------------------------------------------------------------
  logic take;
  logic dual_reg;
  logic [1:0] mode_reg;
  logic [2:0] mask_reg;
  assign take = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[1:0] == 2'b11;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dual_reg <= 1'b0;
      mode_reg <= 2'b00;
      mask_reg <= 3'b000;
    end else if (take) begin
      if (wb_adr_in == pwm_gen_pkg::ADDR_TRIGGER_CONTROL) dual_reg <= wb_dat_in[7];
      if (wb_adr_in == pwm_gen_pkg::ADDR_GENERATOR_CONTROL) mode_reg <= wb_dat_in[3:2];
      if (wb_adr_in == pwm_gen_pkg::ADDR_IRQ_MASK) mask_reg <= wb_dat_in[2:0];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_rd(logic [7:0] a);
    wb_ack_out && !wb_we_in && wb_adr_in == a;
  endsequence
  sequence s_red_hold;
    (mode_reg == pwm_gen_pkg::MODE_REDUNDANT) [*3];
  endsequence
  chk_ack_once: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack not one cycle after request");
  chk_rdata_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h00000000)
    else $error("read data not zero outside ack");
  chk_dt_upper: assert property (
    s_rd(pwm_gen_pkg::ADDR_DEAD_PRIMARY) |-> wb_dat_out[31:14] == 18'h00000)
    else $error("dead time upper bits not zero");
  chk_alt_upper: assert property (
    s_rd(pwm_gen_pkg::ADDR_DEAD_ALTERNATE) |-> wb_dat_out[31:14] == 18'h00000)
    else $error("alternate dead time upper bits not zero");
  chk_trg_unused: assert property (
    s_rd(pwm_gen_pkg::ADDR_TRIGGER_CONTROL) |->
      (wb_dat_out & ~{16'h0000, pwm_gen_pkg::TRIGGER_CONTROL_MASK}) == 32'h00000000)
    else $error("trigger control unused bits not zero");
  chk_dual_merge: assert property (
    dual_reg && $past(dual_reg) |-> !trigger_secondary_out)
    else $error("separate secondary trigger in dual mode");
  chk_sec_indep: assert property (
    trigger_secondary_out |-> mode_reg == 2'b11 || $past(mode_reg) == 2'b11)
    else $error("secondary trigger outside independent mode");
  chk_redundant_pair: assert property (s_red_hold |-> low_output_out == high_output_out)
    else $error("redundant outputs differ");
  chk_irq_masked: assert property (mask_reg == 3'b000 && $past(mask_reg) == 3'b000 |-> !irq_out)
    else $error("interrupt with all sources masked");
endmodule // pwm_phase_deadtime_trigger_checker

bind pwm_phase_deadtime_trigger pwm_phase_deadtime_trigger_checker u_chk (
  .clk_sys_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
  .wb_dat_in, .wb_dat_out, .wb_ack_out, .high_output_out, .low_output_out,
  .trigger_primary_out, .trigger_secondary_out, .irq_out
);

// ---- testbench/pwm_phase_deadtime_trigger_tb_top.sv ----
module pwm_phase_deadtime_trigger_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CTL = pwm_gen_pkg::ADDR_GENERATOR_CONTROL;
  localparam logic [7:0] A_TRG = pwm_gen_pkg::ADDR_TRIGGER_CONTROL;
  localparam logic [7:0] A_SDC = pwm_gen_pkg::ADDR_SECONDARY_DUTY;
  localparam logic [7:0] A_ST = pwm_gen_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] A_MSK = pwm_gen_pkg::ADDR_IRQ_MASK;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic ack, hi, lo, trg_p, trg_s, irq;
  logic [15:0] hw, lw, lr;
  int n_mismatch = 0, tests_run = 0, cycles = 0, p, d, k;
  logic [7:0] addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [15:0] masks [6] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h3FFF, 16'h3FFF, 16'hF0BF};
  logic [3:0] divs [2] = '{4'h1, 4'hF};
  pwm_phase_deadtime_trigger u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .high_output_out(hi),
    .low_output_out(lo), .trigger_primary_out(trg_p), .trigger_secondary_out(trg_s),
    .irq_out(irq));
  pwm_power_stage_model u_stage (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .high_output_in(hi), .low_output_in(lo), .high_width_out(hw), .low_width_out(lw),
    .low_rises_out(lr));
  initial forever #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    @(posedge clk_sys_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= dv;
    do @(posedge clk_sys_in); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic wait_trig(output int n);
    n = 0;
    do begin @(posedge clk_sys_in); n++; end while (trg_p !== 1'b1);
  endtask
  task automatic settle;
    repeat (3) wait_trig(d);
  endtask
  task automatic count_sec(input int len, output int c);
    c = 0;
    repeat (len) begin @(posedge clk_sys_in); if (trg_s === 1'b1) c++; end
  endtask
  task automatic gap(output int g);
    g = 0;
    do @(posedge clk_sys_in); while (hi !== 1'b0);
    do @(posedge clk_sys_in); while (hi !== 1'b1);
    while (lo !== 1'b1) begin @(posedge clk_sys_in); g++; end
  endtask
  task automatic start(input logic [15:0] trg, input logic [15:0] ctl);
    wb(1'b1, A_CTL, 32'h0);
    wb(1'b1, A_TRG, {16'h0, trg});
    wb(1'b1, A_CTL, {16'h0, ctl});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    foreach (addrs[i]) rdchk(addrs[i], 32'h0);
    rdchk(pwm_gen_pkg::ADDR_MASTER_PERIOD, 32'h0000FFFF);
    foreach (addrs[i]) begin
      wb(1'b1, addrs[i], 32'hFFFFFFFF);
      rdchk(addrs[i], {16'h0, masks[i]});
    end
    wb(1'b1, 8'h3C, 32'h00001234);
    rdchk(8'h3C, 32'h0);
    $display("test registers done");
    wb(1'b1, pwm_gen_pkg::ADDR_MASTER_PERIOD, 32'h30);
    wb(1'b1, pwm_gen_pkg::ADDR_PRIMARY_DUTY, 32'h10);
    wb(1'b1, A_SDC, 32'h20);
    start(16'h0000, 16'h0001);
    settle;
    wait_trig(p);
    check(hw, 32'h10);
    check(lw, 32'(p - 16));
    foreach (divs[i]) begin
      start({divs[i], 12'h000}, 16'h0001);
      wait_trig(d);
      wait_trig(d);
      check(32'(d), 32'((divs[i] + 1) * p));
    end
    start(16'h0004, 16'h0001);
    wait_trig(d);
    check(32'(d >= 4 * p && d <= 6 * p), 32'h1);
    $display("test period and trigger done");
    start(16'h0000, 16'h000D);
    settle;
    check(lw, 32'h20);
    gap(k);
    check(32'(k), 32'h2);
    count_sec(4 * p, k);
    check(32'(k), 32'h4);
    start(16'h0080, 16'h000D);
    count_sec(4 * p, k);
    check(32'(k), 32'h0);
    wb(1'b1, A_SDC, 32'h4);
    settle;
    k = int'(lr);
    settle;
    check(lr, 32'(k));
    wb(1'b1, A_SDC, 32'h20);
    start(16'h0000, 16'h0005);
    settle;
    check(lw, 32'h10);
    wb(1'b1, pwm_gen_pkg::ADDR_PRIMARY_DUTY, 32'h9);
    settle;
    check(hw, 32'h8);
    start(16'h0000, 16'h0009);
    settle;
    check(lw, 32'h8);
    $display("test pin modes done");
    wb(1'b1, pwm_gen_pkg::ADDR_MASTER_PERIOD, 32'h60);
    wb(1'b1, pwm_gen_pkg::ADDR_PRIMARY_PHASE, 32'h30);
    start(16'h0000, 16'h0003);
    settle;
    wait_trig(d);
    check(32'(d), 32'(p));
    wb(1'b1, pwm_gen_pkg::ADDR_PRIMARY_DUTY, 32'h2E);
    settle;
    check(hw, 32'h28);
    start(16'h0000, 16'h000F);
    settle;
    count_sec(4 * p, k);
    check(32'(k), 32'h4);
    $display("test independent period done");
    wb(1'b1, A_MSK, 32'h3);
    start(16'h0000, 16'h000D);
    settle;
    check(irq, 1'b1);
    wb(1'b0, A_ST, 32'h0);
    check(rd & 32'h3, 32'h1);
    wb(1'b1, A_CTL, 32'h0);
    wb(1'b1, A_ST, 32'h7);
    rdchk(A_ST, 32'h0);
    check(irq, 1'b0);
    wb(1'b1, A_MSK, 32'h0);
    start(16'h0000, 16'h0001);
    settle;
    check(irq, 1'b0);
    wb(1'b1, A_MSK, 32'h1);
    repeat (2) @(posedge clk_sys_in);
    check(irq, 1'b1);
    $display("test interrupt done");
    summarize();
  end
endmodule // pwm_phase_deadtime_trigger_tb_top
